// file: rtl/rkpc_rotary_knob.sv
`timescale 1ns/1ps
// Overview of operation
// - direction flag latched high on counterclockwise rotation
// - direction flag driven low on clockwise rotation
// - knob edge starts a 90 ms counting window
// - pulses gated into the counter from the edge that opens the window until the window expires
// - window cannot be retriggered until it has expired, its interrupt pulse has ended and a counter clear has followed
// - counter is a divide-by-16 chain of halving stages
// - one narrow active-high knob interrupt per window
// - interrupt forwarded active low on the shared panel line
// - active-low clear becomes active-high counter clear pulse
// - any low keyboard sense line also pulls the shared line low
module rkpc_rotary_knob #(
   parameter int WINDOW_CYCLES = rkpc_pkg::WINDOW_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire rkpc_pkg::rkpc_knob_t knob,
   input wire logic [7:0] keySense_n,
   input wire logic knob_clear_n,
   output logic knobIrq,
   output logic panel_irq_n,
   output logic knobCounterClear,
   output rkpc_pkg::rkpc_status_t status
);
   import rkpc_pkg::*;

   typedef struct packed {
      rkpc_state_t st;
      logic aPrev;
      logic dir;
      logic [CNT_W-1:0] cnt;
      logic [TMR_W-1:0] tmr;
      logic irq;
      logic irqN;
      logic clr;
      logic clrPrev;
      logic open;
   } rkpc_regs_t;

   rkpc_regs_t r_q;
   rkpc_regs_t r_d;
   logic knobEdge;
   logic [CNT_W-1:0] stageTgl;

   // ------------------------------------------------------------
   // halving stages
   // ------------------------------------------------------------
   // each stage toggles when all lower stages are high and a pulse comes
   genvar g;
   generate
      for (g = 0; g < CNT_W; g++)
      begin : g_stage
         if (g == 0)
         begin : g_first
            assign stageTgl[g] = 1'b1;
         end
         else
         begin : g_next
            assign stageTgl[g] = stageTgl[g-1] & r_q.cnt[g-1];
         end
      end
   endgenerate

   assign knobEdge = r_q.aPrev & ~knob.knobPhaseA;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      r_d = r_q;
      r_d.aPrev = knob.knobPhaseA;
      r_d.clrPrev = knob_clear_n;
      // falling edge of the clear gives a one-cycle high clear
      r_d.clr = r_q.clrPrev & ~knob_clear_n;
      if (knobEdge)
      begin
         r_d.dir = knob.knobPhaseB;
      end
      r_d.irq = 1'b0;
      case (r_q.st)
         IDLE:
         begin
            if (knobEdge)
            begin
               r_d.st = COUNTING;
               r_d.tmr = TMR_W'(WINDOW_CYCLES - 1);
               r_d.cnt = r_q.cnt ^ stageTgl;
            end
         end
         COUNTING:
         begin
            if (knobEdge)
            begin
               r_d.cnt = r_q.cnt ^ stageTgl;
            end
            if (r_q.tmr == '0)
            begin
               r_d.st = IRQ;
               r_d.tmr = TMR_W'(IRQ_PULSE_CYC - 1);
            end
            else
            begin
               r_d.tmr = r_q.tmr - 1'b1;
            end
         end
         IRQ:
         begin
            r_d.irq = 1'b1;
            if (r_q.tmr == '0)
            begin
               r_d.st = WAITCLR;
            end
            else
            begin
               r_d.tmr = r_q.tmr - 1'b1;
            end
         end
         WAITCLR:
         begin
            if (r_q.clr)
            begin
               r_d.st = IDLE;
            end
         end
         default:
         begin
            r_d.st = IDLE;
         end
      endcase
      if (r_q.clr)
      begin
         r_d.cnt = CNT_RST;
      end
      // registered copy of the window state for the status output
      r_d.open = (r_d.st == COUNTING);
      r_d.irqN = ~(r_d.irq | ~(&keySense_n));
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r_q <= '{st: IDLE, aPrev: 1'b1, dir: 1'b0, cnt: CNT_RST,
                  tmr: '0, irq: 1'b0, irqN: 1'b1, clr: 1'b0,
                  clrPrev: 1'b1, open: 1'b0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign knobIrq = r_q.irq;
   assign panel_irq_n = r_q.irqN;
   assign knobCounterClear = r_q.clr;
   assign status = '{count: r_q.cnt, direction: r_q.dir,
                     windowOpen: r_q.open};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_start;
      r_q.st == IDLE && knobEdge;
   endsequence

   property p_dir;
      @(posedge clock) disable iff (rst)
      knobEdge |=> status.direction == $past(knob.knobPhaseB);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");

   property p_start;
      @(posedge clock) disable iff (rst)
      s_start |=> status.windowOpen;
   endproperty
   a_start: assert property (p_start) else $error("no window");

   property p_noretrig;
      @(posedge clock) disable iff (rst)
      $rose(status.windowOpen) |=> status.windowOpen [*8];
   endproperty
   a_noretrig: assert property (p_noretrig) else $error("retrigger");

   property p_relock;
      @(posedge clock) disable iff (rst)
      ((r_q.st == IRQ || r_q.st == WAITCLR) && knobEdge) |=>
         !status.windowOpen;
   endproperty
   a_relock: assert property (p_relock) else $error("window reopened");

   property p_count;
      @(posedge clock) disable iff (rst || r_q.clr)
      (r_q.st == COUNTING && knobEdge) |=>
         status.count == $past(status.count) + 4'h1;
   endproperty
   a_count: assert property (p_count) else $error("count slip");

   property p_hold;
      @(posedge clock) disable iff (rst || r_q.clr)
      (r_q.st != COUNTING && r_q.st != IDLE) |=> $stable(status.count);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");

   property p_irq;
      @(posedge clock) disable iff (rst)
      $rose(knobIrq) |-> knobIrq [*4] ##1 !knobIrq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq width");

   property p_irqn;
      @(posedge clock) disable iff (rst)
      knobIrq |-> !panel_irq_n;
   endproperty
   a_irqn: assert property (p_irqn) else $error("shared irq");

   sequence s_clrPulse;
      knobCounterClear ##1 (!knobCounterClear && status.count == CNT_RST);
   endsequence

   property p_clr;
      @(posedge clock) disable iff (rst)
      $fell(knob_clear_n) |=> s_clrPulse;
   endproperty
   a_clr: assert property (p_clr) else $error("clear failed");

   property p_kbd;
      @(posedge clock) disable iff (rst)
      !(&keySense_n) |=> !panel_irq_n;
   endproperty
   a_kbd: assert property (p_kbd) else $error("kbd irq");
endmodule // rkpc_rotary_knob

// file: rtl/rkpc_pkg.sv
package rkpc_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int WINDOW_MS = 90;
   localparam int WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS;
   localparam int IRQ_PULSE_CYC = 4;
   localparam int CNT_W = 4;
   localparam int TMR_W = 23;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic knobPhaseA;
      logic knobPhaseB;
   } rkpc_knob_t;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic direction;
      logic windowOpen;
   } rkpc_status_t;

   typedef enum logic [1:0] {IDLE, COUNTING, IRQ, WAITCLR} rkpc_state_t;
endpackage

// file: test/rkpc_knob_model.sv
`timescale 1ns/1ps
module rkpc_knob_model (
   input wire logic clock,
   output rkpc_pkg::rkpc_knob_t knob,
   output logic knob_clear_n
);
   import rkpc_pkg::*;
   initial
   begin
      knob = 2'h3;
      knob_clear_n = 1'b1;
   end
   // n falling edges on A, B held at the turn direction
   task automatic turn(int n, logic ccw, int gap);
      repeat (n)
      begin
         @(posedge clock) knob <= {1'b0, ccw};
         repeat (gap) @(posedge clock);
         knob.knobPhaseA <= 1'b1;
         repeat (gap) @(posedge clock);
      end
   endtask
   task automatic clear();
      @(posedge clock) knob_clear_n <= 1'b0;
      repeat (2) @(posedge clock);
      knob_clear_n <= 1'b1;
   endtask
endmodule // rkpc_knob_model

// file: test/rkpc_tb_top.sv
`timescale 1ns/1ps
module rotary_knob_pulse_counter_tb_top;
   import rkpc_pkg::*;
   localparam int WIN = 80;
   logic clock, rst, knob_clear_n, knobIrq, panel_irq_n, knobCounterClear;
   logic [7:0] keySense_n;
   rkpc_knob_t knob;
   rkpc_status_t status;
   int fails, checks_done, span;
   rkpc_rotary_knob #(.WINDOW_CYCLES(WIN)) dut (.clock(clock), .rst(rst),
      .knob(knob), .keySense_n(keySense_n), .knob_clear_n(knob_clear_n),
      .knobIrq(knobIrq), .panel_irq_n(panel_irq_n),
      .knobCounterClear(knobCounterClear), .status(status));
   rkpc_knob_model model (.clock(clock), .knob(knob),
      .knob_clear_n(knob_clear_n));
   function automatic logic [3:0] expCount(int n);
      return 4'(n % 16);
   endfunction
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // 0 window open, 1 irq, 2 counter clear
   task automatic await(int which, int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(posedge clock);
         #1;
         if ((which == 0 && status.windowOpen === 1'b1) ||
            (which == 1 && knobIrq === 1'b1) ||
            (which == 2 && knobCounterClear === 1'b1))
            break;
      end
      span = i;
      check(8'(i < lim), 8'h1);
   endtask
   task automatic round(int n, logic ccw, int gap);
      fork
         model.turn(n, ccw, gap);
         begin
            await(0, 9);
            await(1, WIN + 9);
            check(8'(span >= WIN - 2 && span <= WIN + 2), 8'h1);
            for (int k = 0; k < IRQ_PULSE_CYC; k++)
            begin
               check(8'({knobIrq, panel_irq_n}), 8'h2);
               @(posedge clock);
               #1;
            end
            check(8'(knobIrq), 8'h0);
         end
      join
      check(8'(status.count), 8'(expCount(n)));
      check(8'(status.direction), 8'(ccw));
      model.turn(3, !ccw, 1);
      @(posedge clock);
      #1;
      check(8'(status), 8'({expCount(n), !ccw, 1'b0}));
      fork
         model.clear();
         await(2, 6);
      join_any
      @(posedge clock);
      #1;
      check(8'({knobCounterClear, status.count}), 8'h0);
      wait fork;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial
   begin
      repeat (5000) @(posedge clock);
      fails++;
      close_out();
   end
   initial
   begin
      rst = 1'b1;
      keySense_n = 8'hff;
      void'($urandom(57));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check({status, knobIrq, panel_irq_n}, 8'h01);
      round(1, 1'b1, 1);
      round(16, 1'b0, 1);
      round(17, 1'b1, 1);
      repeat (4) round($urandom_range(15, 1), 1'($urandom_range(1, 0)),
         $urandom_range(2, 1));
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clock) keySense_n <= ~(8'h01 << k);
         repeat (2) @(posedge clock);
         #1;
         check(8'(panel_irq_n), 8'h0);
         @(posedge clock) keySense_n <= 8'hff;
         repeat (2) @(posedge clock);
         #1;
         check(8'(panel_irq_n), 8'h1);
      end
      close_out();
   end
endmodule // rotary_knob_pulse_counter_tb_top
